// [shared/status_flags_pkg.sv]
// Purpose: Shared constants for the audio path status flag block.
// Assumes: Register indices are word indices; the byte address is four times the index.
// Notes:   Raw flag and event bit positions are used by the core and by the testbench.

`default_nettype none

package status_flags_pkg;

	// Register bus geometry.
	localparam int          ADDR_W          = 16;
	localparam int          DATA_W          = 8;
	localparam int          IDX_W           = 14;

	// Register indices.
	localparam logic [13:0] IDX_ADC_OVF     = 14'h1301;
	localparam logic [13:0] IDX_MIX_OVF     = 14'h1302;
	localparam logic [13:0] IDX_CONV_LOCK   = 14'h1303;
	localparam logic [13:0] IDX_INT_STATUS  = 14'h1310;
	localparam logic [13:0] IDX_INT_MASK    = 14'h1311;
	localparam logic [13:0] IDX_LINK_STATUS = 14'h1312;
	localparam logic [13:0] IDX_CLIP_COUNT  = 14'h1313;

	// Raw flag vector positions, as sampled from the audio paths.
	localparam int          FLAG_W          = 9;
	localparam int          FLAG_CAPTURE    = 0;
	localparam int          FLAG_SECTION    = 1;
	localparam int          FLAG_PATH       = 2;
	localparam int          FLAG_MIX_LEFT   = 3;
	localparam int          FLAG_MIX_RIGHT  = 4;
	localparam int          FLAG_OUT_UNLK   = 5;
	localparam int          FLAG_IN_UNLK    = 6;
	localparam int          FLAG_OUT_LK     = 7;
	localparam int          FLAG_IN_LK      = 8;

	// Events: the lower raw flags whose rising edge is an interrupt event.
	localparam int          EVT_W           = 7;

	// Field positions inside the readable registers.
	localparam int          ADC_CLIP_BIT    = 0;
	localparam int          MIX_SECTION_BIT = 3;
	localparam int          MIX_PATH_BIT    = 2;
	localparam int          MIX_LEFT_BIT    = 1;
	localparam int          MIX_RIGHT_BIT   = 0;
	localparam int          CONV_OUT_UNLK   = 3;
	localparam int          CONV_IN_UNLK    = 2;
	localparam int          CONV_OUT_LK     = 1;
	localparam int          CONV_IN_LK      = 0;
	localparam int          LINK_ACTIVE_BIT = 0;

	// Reset values and clip counter constants.
	localparam logic [7:0]  RST_BYTE        = 8'h00;
	localparam logic [7:0]  RST_MASK        = 8'h00;
	localparam logic [7:0]  CLIP_COUNT_MAX  = 8'hff;
	localparam logic [7:0]  CLIP_COUNT_ONE  = 8'h01;

	// Frame clock watchdog timing.
	localparam int          CLK_MHZ         = 100;
	localparam int          FRAME_IDLE_US   = 1000;
	localparam int          FRAME_IDLE_CYC  = FRAME_IDLE_US * CLK_MHZ;

endpackage : status_flags_pkg

`default_nettype wire

// [shared/flag_edge_if.sv]
// Purpose: Carries sampled flag levels and their rising-edge pulses between modules.
// Assumes: One producer, the edge unit, and one consumer, the status core.
// Notes:   Width is a parameter so the same carrier serves any flag count.

`timescale 1ns/10ps
`default_nettype none

interface flag_edge_if #(
	parameter int W = 9
);
	logic [W-1:0] level;
	logic [W-1:0] rise;

	modport producer (
		output level,
		output rise
	);

	modport consumer (
		input  level,
		input  rise
	);
endinterface : flag_edge_if

`default_nettype wire

// [hw/flag_edge_unit.sv]
// Purpose: Samples the raw status flags and flags each 0 to 1 transition.
// Assumes: Flag inputs are synchronous to the system clock.
// Notes:   A rise pulse lasts one cycle, the cycle after the sampled level goes high.

`timescale 1ns/10ps
`default_nettype none

module flag_edge_unit #(
	parameter int W = 9
) (
	// Clock and reset.
	input  wire logic         i_clk,
	input  wire logic         i_rst_b,
	// Raw flags.
	input  wire logic [W-1:0] i_flags,
	// Sampled levels and edges.
	flag_edge_if.producer     edges
);

	logic [W-1:0] level_reg;
	logic [W-1:0] prev_reg;
	logic [W-1:0] rise_reg;

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			level_reg <= '0;
			prev_reg  <= '0;
		end else begin
			level_reg <= i_flags;
			prev_reg  <= level_reg;
		end
	end

	always_ff @(posedge i_clk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rise_reg <= '0;
		end else begin
			rise_reg <= level_reg & ~prev_reg;
		end
	end

	assign edges.level = level_reg;
	assign edges.rise  = rise_reg;

endmodule : flag_edge_unit

`default_nettype wire

// [hw/audio_path_status_flags.sv]
// Purpose: Read-only clip and converter lock status with edge-triggered interrupts.
// Assumes: Status inputs and the frame clock input are synchronous to I_SYS_CLK.
// Notes:   Registers sit at byte address four times their index; read data lasts one cycle.

`timescale 1ns/10ps
`default_nettype none

module audio_path_status_flags #(
	parameter int FRAME_IDLE_CYCLES = status_flags_pkg::FRAME_IDLE_CYC
) (
	// Clock and reset.
	input  wire logic                                    I_SYS_CLK,
	input  wire logic                                    I_RST_B,
	// Register port.
	input  wire logic [status_flags_pkg::ADDR_W-1:0]     I_ADDR,
	input  wire logic [status_flags_pkg::DATA_W-1:0]     I_WR_DATA,
	input  wire logic                                    I_WR_STB,
	input  wire logic                                    I_RD_STB,
	output var  logic [status_flags_pkg::DATA_W-1:0]     O_RD_DATA,
	// Clip flags from the audio paths.
	input  wire logic                                    I_CAPTURE_PATH_CLIP_FLAG,
	input  wire logic                                    I_FILTER_SECTION_CLIP_FLAG,
	input  wire logic                                    I_FILTER_PATH_CLIP_FLAG,
	input  wire logic                                    I_MIXER_LEFT_CLIP_FLAG,
	input  wire logic                                    I_MIXER_RIGHT_CLIP_FLAG,
	// Sample-rate converter lock flags.
	input  wire logic                                    I_OUT_RATE_CONV_UNLOCKED,
	input  wire logic                                    I_IN_RATE_CONV_UNLOCKED,
	input  wire logic                                    I_OUT_RATE_CONV_LOCKED,
	input  wire logic                                    I_IN_RATE_CONV_LOCKED,
	// Serial port frame clock, sampled as a level.
	input  wire logic                                    I_FRAME_CLOCK,
	// Interrupt.
	output var  logic                                    O_IRQ
);

	import status_flags_pkg::*;

	localparam int IDLE_W = $clog2(FRAME_IDLE_CYCLES + 1);
	localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(FRAME_IDLE_CYCLES);
	localparam logic [IDLE_W-1:0] IDLE_ONE   = IDLE_W'(1);

	typedef enum {
		LINK_IDLE,
		LINK_ACTIVE
	} link_state_t;

	// True when a bus address selects the register at the given index.
	function automatic logic addr_hit(
		input logic [ADDR_W-1:0] addr,
		input logic [IDX_W-1:0]  idx
	);
		addr_hit = (addr == {idx, 2'b00});
	endfunction : addr_hit

	// Raw flag gathering and edge detection.
	logic [FLAG_W-1:0] raw_flags;

	flag_edge_if #(.W(FLAG_W)) flag_bus ();

	assign raw_flags[FLAG_CAPTURE]   = I_CAPTURE_PATH_CLIP_FLAG;
	assign raw_flags[FLAG_SECTION]   = I_FILTER_SECTION_CLIP_FLAG;
	assign raw_flags[FLAG_PATH]      = I_FILTER_PATH_CLIP_FLAG;
	assign raw_flags[FLAG_MIX_LEFT]  = I_MIXER_LEFT_CLIP_FLAG;
	assign raw_flags[FLAG_MIX_RIGHT] = I_MIXER_RIGHT_CLIP_FLAG;
	assign raw_flags[FLAG_OUT_UNLK]  = I_OUT_RATE_CONV_UNLOCKED;
	assign raw_flags[FLAG_IN_UNLK]   = I_IN_RATE_CONV_UNLOCKED;
	assign raw_flags[FLAG_OUT_LK]    = I_OUT_RATE_CONV_LOCKED;
	assign raw_flags[FLAG_IN_LK]     = I_IN_RATE_CONV_LOCKED;

	flag_edge_unit #(
		.W       (FLAG_W)
	) u_edges (
		.i_clk   (I_SYS_CLK),
		.i_rst_b (I_RST_B),
		.i_flags (raw_flags),
		.edges   (flag_bus.producer)
	);

	// Read-only status views built from the sampled levels.
	logic [DATA_W-1:0] adc_view;
	logic [DATA_W-1:0] mix_view;
	logic [DATA_W-1:0] conv_view;

	always_comb begin
		adc_view               = RST_BYTE;
		adc_view[ADC_CLIP_BIT] = flag_bus.level[FLAG_CAPTURE];
	end

	always_comb begin
		mix_view                  = RST_BYTE;
		mix_view[MIX_SECTION_BIT] = flag_bus.level[FLAG_SECTION];
		mix_view[MIX_PATH_BIT]    = flag_bus.level[FLAG_PATH];
		mix_view[MIX_LEFT_BIT]    = flag_bus.level[FLAG_MIX_LEFT];
		mix_view[MIX_RIGHT_BIT]   = flag_bus.level[FLAG_MIX_RIGHT];
	end

	always_comb begin
		conv_view                = RST_BYTE;
		conv_view[CONV_OUT_UNLK] = flag_bus.level[FLAG_OUT_UNLK];
		conv_view[CONV_IN_UNLK]  = flag_bus.level[FLAG_IN_UNLK];
		conv_view[CONV_OUT_LK]   = flag_bus.level[FLAG_OUT_LK];
		conv_view[CONV_IN_LK]    = flag_bus.level[FLAG_IN_LK];
	end

	// Decoded bus strobes.
	logic wr_int_status;
	logic wr_int_mask;
	logic wr_clip_count;

	assign wr_int_status = I_WR_STB && addr_hit(I_ADDR, IDX_INT_STATUS);
	assign wr_int_mask   = I_WR_STB && addr_hit(I_ADDR, IDX_INT_MASK);
	assign wr_clip_count = I_WR_STB && addr_hit(I_ADDR, IDX_CLIP_COUNT);

	// Sticky interrupt status, one bit for each event.
	logic [DATA_W-1:0] int_status_reg;
	logic [DATA_W-1:0] int_status_next;
	logic [DATA_W-1:0] int_mask_reg;

	// A new rising edge in the same cycle as a write-one-to-clear keeps the bit set.
	genvar g;
	generate
		for (g = 0; g < DATA_W; g++) begin : g_sticky
			if (g < EVT_W) begin : g_event
				always_comb begin
					int_status_next[g] = flag_bus.rise[g]
						| (int_status_reg[g] & ~(wr_int_status & I_WR_DATA[g]));
				end
			end else begin : g_unused
				always_comb begin
					int_status_next[g] = 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			int_status_reg <= RST_BYTE;
		end else begin
			int_status_reg <= int_status_next;
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			int_mask_reg <= RST_MASK;
		end else if (wr_int_mask) begin
			int_mask_reg <= I_WR_DATA & {{(DATA_W-EVT_W){1'b0}}, {EVT_W{1'b1}}};
		end
	end

	// Interrupt line: high while any enabled sticky bit is set.
	logic irq_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(int_status_next & int_mask_reg);
		end
	end

	assign O_IRQ = irq_reg;

	// Count of filter path clip events, so software can judge repetition.
	logic [DATA_W-1:0] clip_count_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			clip_count_reg <= RST_BYTE;
		end else if (flag_bus.rise[FLAG_PATH]) begin
			if (wr_clip_count) begin
				clip_count_reg <= CLIP_COUNT_ONE;
			end else if (clip_count_reg != CLIP_COUNT_MAX) begin
				clip_count_reg <= clip_count_reg + CLIP_COUNT_ONE;
			end
		end else if (wr_clip_count) begin
			clip_count_reg <= RST_BYTE;
		end
	end

	// Frame clock watchdog: the lock flags only mean something while frames run.
	logic              frame_clk_reg;
	logic              frame_clk_prev_reg;
	logic              frame_toggle;
	logic [IDLE_W-1:0] idle_cnt_reg;
	link_state_t       link_state_reg;
	link_state_t       link_state_next;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			frame_clk_reg      <= 1'b0;
			frame_clk_prev_reg <= 1'b0;
		end else begin
			frame_clk_reg      <= I_FRAME_CLOCK;
			frame_clk_prev_reg <= frame_clk_reg;
		end
	end

	assign frame_toggle = frame_clk_reg ^ frame_clk_prev_reg;

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			idle_cnt_reg <= '0;
		end else if (frame_toggle) begin
			idle_cnt_reg <= '0;
		end else if (idle_cnt_reg != IDLE_LIMIT) begin
			idle_cnt_reg <= idle_cnt_reg + IDLE_ONE;
		end
	end

	always_comb begin
		link_state_next = link_state_reg;
		case (link_state_reg)
			LINK_IDLE: begin
				if (frame_toggle) begin
					link_state_next = LINK_ACTIVE;
				end
			end
			LINK_ACTIVE: begin
				if (!frame_toggle && idle_cnt_reg == IDLE_LIMIT) begin
					link_state_next = LINK_IDLE;
				end
			end
			default: begin
				link_state_next = LINK_IDLE;
			end
		endcase
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			link_state_reg <= LINK_IDLE;
		end else begin
			link_state_reg <= link_state_next;
		end
	end

	logic [DATA_W-1:0] link_view;

	always_comb begin
		link_view                  = RST_BYTE;
		link_view[LINK_ACTIVE_BIT] = (link_state_reg == LINK_ACTIVE);
	end

	// Read path: data stands only in the cycle after the read strobe.
	// Writes to the three status registers match no write strobe and change nothing.
	logic [DATA_W-1:0] rd_data_reg;
	logic [DATA_W-1:0] rd_data_next;

	always_comb begin
		rd_data_next = RST_BYTE;
		if (I_RD_STB) begin
			if (addr_hit(I_ADDR, IDX_ADC_OVF)) begin
				rd_data_next = adc_view;
			end else if (addr_hit(I_ADDR, IDX_MIX_OVF)) begin
				rd_data_next = mix_view;
			end else if (addr_hit(I_ADDR, IDX_CONV_LOCK)) begin
				rd_data_next = conv_view;
			end else if (addr_hit(I_ADDR, IDX_INT_STATUS)) begin
				rd_data_next = int_status_reg;
			end else if (addr_hit(I_ADDR, IDX_INT_MASK)) begin
				rd_data_next = int_mask_reg;
			end else if (addr_hit(I_ADDR, IDX_LINK_STATUS)) begin
				rd_data_next = link_view;
			end else if (addr_hit(I_ADDR, IDX_CLIP_COUNT)) begin
				rd_data_next = clip_count_reg;
			end else begin
				rd_data_next = RST_BYTE;
			end
		end
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			rd_data_reg <= RST_BYTE;
		end else begin
			rd_data_reg <= rd_data_next;
		end
	end

	assign O_RD_DATA = rd_data_reg;

endmodule : audio_path_status_flags

`default_nettype wire

// [testbench/audio_path_status_flags_assertions.sv]
// Purpose: Concurrent checks on read data, status views and the interrupt output.
// Assumes: Mask register sits at byte address 16'h4c44 and is shadowed here from bus writes.
// Notes:   Bound to the top module after the checker.
`timescale 1ns/10ps
`default_nettype none
module audio_path_status_flags_assertions (
	input wire logic                                I_SYS_CLK,
	input wire logic                                I_RST_B,
	input wire logic [status_flags_pkg::ADDR_W-1:0] I_ADDR,
	input wire logic [status_flags_pkg::DATA_W-1:0] I_WR_DATA,
	input wire logic                                I_WR_STB,
	input wire logic                                I_RD_STB,
	input wire logic [status_flags_pkg::DATA_W-1:0] O_RD_DATA,
	input wire logic                                I_CAPTURE_PATH_CLIP_FLAG,
	input wire logic                                I_FILTER_SECTION_CLIP_FLAG,
	input wire logic                                I_FILTER_PATH_CLIP_FLAG,
	input wire logic                                I_MIXER_LEFT_CLIP_FLAG,
	input wire logic                                I_MIXER_RIGHT_CLIP_FLAG,
	input wire logic                                I_OUT_RATE_CONV_UNLOCKED,
	input wire logic                                I_IN_RATE_CONV_UNLOCKED,
	input wire logic                                I_OUT_RATE_CONV_LOCKED,
	input wire logic                                I_IN_RATE_CONV_LOCKED,
	input wire logic                                O_IRQ
);
	import status_flags_pkg::*;
	logic [7:0] mask_reg;
	logic [6:0] evt;
	logic [3:0] mix;
	logic [3:0] conv;
	logic       mapped;
	assign evt = {I_IN_RATE_CONV_UNLOCKED, I_OUT_RATE_CONV_UNLOCKED, I_MIXER_RIGHT_CLIP_FLAG,
		I_MIXER_LEFT_CLIP_FLAG, I_FILTER_PATH_CLIP_FLAG, I_FILTER_SECTION_CLIP_FLAG, I_CAPTURE_PATH_CLIP_FLAG};
	assign mix = {I_FILTER_SECTION_CLIP_FLAG, I_FILTER_PATH_CLIP_FLAG, I_MIXER_LEFT_CLIP_FLAG, I_MIXER_RIGHT_CLIP_FLAG};
	assign conv = {I_OUT_RATE_CONV_UNLOCKED, I_IN_RATE_CONV_UNLOCKED, I_OUT_RATE_CONV_LOCKED, I_IN_RATE_CONV_LOCKED};
	assign mapped = I_ADDR inside {16'h4c04, 16'h4c08, 16'h4c0c, 16'h4c40, 16'h4c44, 16'h4c48, 16'h4c4c};
	always_ff @(posedge I_SYS_CLK or negedge I_RST_B) begin
		if (!I_RST_B) begin
			mask_reg <= RST_MASK;
		end else if (I_WR_STB && I_ADDR == 16'h4c44) begin
			mask_reg <= I_WR_DATA;
		end
	end
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RST_B);
	// A sampled rising flag whose mask bit is enabled.
	sequence unmasked_rise;
		|(evt & ~$past(evt) & mask_reg[6:0]);
	endsequence
	a_adc_view: assert property (I_RD_STB && I_ADDR == 16'h4c04 && $stable(I_CAPTURE_PATH_CLIP_FLAG) |=>
		O_RD_DATA == {7'h00, $past(I_CAPTURE_PATH_CLIP_FLAG)}) else $error("capture clip view wrong");
	a_mix_view: assert property (I_RD_STB && I_ADDR == 16'h4c08 && $stable(mix) |=>
		O_RD_DATA == {4'h0, $past(mix)}) else $error("mixer view wrong");
	a_conv_view: assert property (I_RD_STB && I_ADDR == 16'h4c0c && $stable(conv) |=>
		O_RD_DATA == {4'h0, $past(conv)}) else $error("converter view wrong");
	a_rd_idle_zero: assert property (!I_RD_STB |=> O_RD_DATA == 8'h00) else $error("read data outside read");
	a_rd_unmapped: assert property (I_RD_STB && !mapped |=> O_RD_DATA == 8'h00) else $error("unmapped read");
	a_irq_unmasked: assert property (unmasked_rise |-> ##[1:3] O_IRQ) else $error("event gave no interrupt");
	a_irq_masked_off: assert property (mask_reg == 8'h00 && $past(mask_reg) == 8'h00 |-> !O_IRQ)
		else $error("interrupt while masked");
	a_irq_sticky_hold: assert property (O_IRQ && !I_WR_STB && !$past(I_WR_STB) |=> O_IRQ)
		else $error("interrupt dropped");
endmodule : audio_path_status_flags_assertions
bind audio_path_status_flags audio_path_status_flags_assertions chk_u (.I_SYS_CLK(I_SYS_CLK),
	.I_RST_B(I_RST_B), .I_ADDR(I_ADDR), .I_WR_DATA(I_WR_DATA), .I_WR_STB(I_WR_STB), .I_RD_STB(I_RD_STB),
	.O_RD_DATA(O_RD_DATA), .I_CAPTURE_PATH_CLIP_FLAG(I_CAPTURE_PATH_CLIP_FLAG),
	.I_FILTER_SECTION_CLIP_FLAG(I_FILTER_SECTION_CLIP_FLAG), .I_FILTER_PATH_CLIP_FLAG(I_FILTER_PATH_CLIP_FLAG),
	.I_MIXER_LEFT_CLIP_FLAG(I_MIXER_LEFT_CLIP_FLAG), .I_MIXER_RIGHT_CLIP_FLAG(I_MIXER_RIGHT_CLIP_FLAG),
	.I_OUT_RATE_CONV_UNLOCKED(I_OUT_RATE_CONV_UNLOCKED), .I_IN_RATE_CONV_UNLOCKED(I_IN_RATE_CONV_UNLOCKED),
	.I_OUT_RATE_CONV_LOCKED(I_OUT_RATE_CONV_LOCKED), .I_IN_RATE_CONV_LOCKED(I_IN_RATE_CONV_LOCKED), .O_IRQ(O_IRQ));
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the status flag views and the edge interrupts.
// Assumes: Byte addresses are four times the register index.
// Notes:   Flags and frame clock come from a fixed-seed shift register in the view loop after two fixed flag passes, then are set by the directed checks.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import status_flags_pkg::*;
	logic        sys_clk;
	logic        rst_b;
	logic        wr_stb;
	logic        rd_stb;
	logic        frame_clk;
	logic        irq;
	logic [15:0] addr;
	logic [7:0]  wr_data;
	logic [7:0]  rd_data;
	logic [7:0]  rd_out;
	logic [8:0]  flags;
	logic [31:0] lfsr;
	logic [15:0] views [4] = '{16'h4c04, 16'h4c08, 16'h4c0c, 16'h4c10};
	int          miscompares;
	int          checked;
	audio_path_status_flags #(.FRAME_IDLE_CYCLES(16)) dut_u (.I_SYS_CLK(sys_clk), .I_RST_B(rst_b),
		.I_ADDR(addr), .I_WR_DATA(wr_data), .I_WR_STB(wr_stb), .I_RD_STB(rd_stb), .O_RD_DATA(rd_out),
		.I_CAPTURE_PATH_CLIP_FLAG(flags[FLAG_CAPTURE]), .I_FILTER_SECTION_CLIP_FLAG(flags[FLAG_SECTION]),
		.I_FILTER_PATH_CLIP_FLAG(flags[FLAG_PATH]), .I_MIXER_LEFT_CLIP_FLAG(flags[FLAG_MIX_LEFT]),
		.I_MIXER_RIGHT_CLIP_FLAG(flags[FLAG_MIX_RIGHT]), .I_OUT_RATE_CONV_UNLOCKED(flags[FLAG_OUT_UNLK]),
		.I_IN_RATE_CONV_UNLOCKED(flags[FLAG_IN_UNLK]), .I_OUT_RATE_CONV_LOCKED(flags[FLAG_OUT_LK]),
		.I_IN_RATE_CONV_LOCKED(flags[FLAG_IN_LK]), .I_FRAME_CLOCK(frame_clk), .O_IRQ(irq));
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : next_rand
	function automatic logic [7:0] exp_view(input logic [15:0] a, input logic [8:0] f);
		case (a)
			16'h4c04: return {7'h00, f[FLAG_CAPTURE]};
			16'h4c08: return {4'h0, f[FLAG_SECTION], f[FLAG_PATH], f[FLAG_MIX_LEFT], f[FLAG_MIX_RIGHT]};
			16'h4c0c: return {4'h0, f[FLAG_OUT_UNLK], f[FLAG_IN_UNLK], f[FLAG_OUT_LK], f[FLAG_IN_LK]};
			default: return 8'h00;
		endcase
	endfunction : exp_view
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wr_data <= d;
		wr_stb <= 1'b1;
		@(posedge sys_clk);
		wr_stb <= 1'b0;
	endtask : wr
	task automatic rd(input logic [15:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge sys_clk);
		rd_stb <= 1'b0;
		#1 rd_data = rd_out;
	endtask : rd
	task automatic wait_irq(input logic exp);
		repeat (4) @(posedge sys_clk);
		#1 check({7'h00, irq}, {7'h00, exp});
	endtask : wait_irq
	task automatic close_out();
		$display("checked %0d, miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : close_out
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		#100000;
		miscompares++;
		close_out();
	end
	initial begin
		{rst_b, wr_stb, rd_stb, frame_clk, addr, wr_data, flags} = '0;
		lfsr = 32'h28600347;
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'b1;
		rd(16'h4c40);
		check(rd_data, 8'h00);
		for (int n = 0; n < 40; n++) begin
			lfsr = next_rand(lfsr);
			@(posedge sys_clk);
			flags <= (n == 0) ? 9'h1ff : (n == 1) ? 9'h000 : lfsr[8:0];
			frame_clk <= lfsr[9];
			// Writes to the read-only views must leave them showing the live flags.
			wr(views[lfsr[11:10] % 3], lfsr[23:16]);
			for (int k = 0; k < 4; k++) begin
				rd(views[k]);
				check(rd_data, exp_view(views[k], flags));
			end
		end
		@(posedge sys_clk);
		flags <= 9'h000;
		repeat (3) @(posedge sys_clk);
		wr(16'h4c44, 8'h00);
		wr(16'h4c40, 8'hff);
		for (int i = 0; i < EVT_W; i++) begin
			@(posedge sys_clk);
			flags[i] <= 1'b1;
			wait_irq(1'b0);
			rd(16'h4c40);
			check(rd_data, 8'h01 << i);
			wr(16'h4c44, 8'h01 << i);
			wait_irq(1'b1);
			wr(16'h4c40, 8'h01 << i);
			wait_irq(1'b0);
			@(posedge sys_clk);
			flags[i] <= 1'b0;
			repeat (2) @(posedge sys_clk);
			flags[i] <= 1'b1;
			wait_irq(1'b1);
			wr(16'h4c44, 8'h00);
			wr(16'h4c40, 8'hff);
			@(posedge sys_clk);
			flags[i] <= 1'b0;
			wait_irq(1'b0);
		end
		// Filter path clips are counted so software can judge repetition; a write empties the count, or loads one if it meets a new clip edge.
		wr(16'h4c4c, 8'h00);
		for (int p = 0; p < 3; p++) begin
			@(posedge sys_clk);
			flags[FLAG_PATH] <= 1'b1;
			repeat (2) @(posedge sys_clk);
			flags[FLAG_PATH] <= 1'b0;
			repeat (2) @(posedge sys_clk);
		end
		rd(16'h4c4c);
		check(rd_data, 8'h03);
		wr(16'h4c4c, 8'h5a);
		rd(16'h4c4c);
		check(rd_data, 8'h00);
		// A clip edge that meets a write-one-to-clear of its own bit keeps the bit set.
		wr(16'h4c40, 8'hff);
		@(posedge sys_clk);
		flags[FLAG_PATH] <= 1'b1;
		@(posedge sys_clk);
		wr(16'h4c40, 8'h04);
		rd(16'h4c40);
		check(rd_data, 8'h04);
		// Lock flags mean something only while frames run, so software reads the link bit first.
		repeat (4) begin
			@(posedge sys_clk);
			frame_clk <= ~frame_clk;
		end
		rd(16'h4c48);
		check(rd_data, 8'h01);
		repeat (24) @(posedge sys_clk);
		rd(16'h4c48);
		check(rd_data, 8'h00);
		// Enabling the mask over a bit that is already set raises the line; bit 7 is not kept.
		wr(16'h4c44, 8'hff);
		rd(16'h4c44);
		check(rd_data, 8'h7f);
		wait_irq(1'b1);
		close_out();
	end
endmodule : tb_top
`default_nettype wire
